//--- adt_defines.svh
// constants for the auto block transfer engine
`ifndef ADT_DEFINES_SVH
`define ADT_DEFINES_SVH
`define REG_CTRL 6'h00
`define REG_TABLE 6'h01
`define REG_STATUS 6'h02
`define REG_POINTER 6'h03
`define CTRL_ENABLE_BIT 0
`define CTRL_START_BIT 1
`define STAT_DONE_BIT 0
`define STAT_ERR_BIT 1
`define STAT_RUN_BIT 2
`define STAT_PHASE_BIT 3
`define STAT_HOLD_BIT 4
`define D1_MULTI_BIT 14
`define D1_CHAR_BIT 13
`define D1_DIR_BIT 11
`define D1_LINK_BIT 1
`define D1_EQUIPMENT_NUMBER_FIELD_HI 10
`define D1_EQUIPMENT_NUMBER_FIELD_LO 7
`define OFS_CUR 15'h0001
`define OFS_LAST 15'h0002
`define OFS_TERM_LO 15'h0001
`define OFS_TERM_HI 15'h0002
`define OFS_DEV_BASE 15'h0004
`define TABLE_RESET 15'h0000
`define SYNC_W 1
`endif

//--- adt_pkg.sv
// types shared by the auto block transfer engine
package adt_pkg;
   typedef logic [15:0] word_t;
   typedef logic [14:0] maddr_t;
   typedef enum logic [3:0] {
      ST_IDLE, ST_HDR, ST_DESC, ST_CUR, ST_LAST, ST_MEM_RD, ST_IO,
      ST_MEM_WR, ST_PTR_WR, ST_TERM_RD, ST_TERM_WR
   } state_t;
endpackage : adt_pkg

//--- adt_sync.sv
// three stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`include "adt_defines.svh"
module adt_sync (
   input wire logic sys_clk, // system clock
   input wire logic reset, // async reset, active high
   input wire logic [`SYNC_W-1:0] pin, // raw pin levels
   output logic [`SYNC_W-1:0] level // filtered levels
);
   logic [`SYNC_W-1:0] s1;
   logic [`SYNC_W-1:0] s2;
   logic [`SYNC_W-1:0] s3;
   genvar i;
   generate
      for (i = 0; i < `SYNC_W; i = i + 1) begin : g_bit
         always_ff @(posedge sys_clk or posedge reset) begin
            if (reset) begin
               s1[i] <= 1'b0;
               s2[i] <= 1'b0;
               s3[i] <= 1'b0;
               level[i] <= 1'b0;
            end else begin
               s1[i] <= pin[i];
               s2[i] <= s1[i];
               s3[i] <= s2[i];
               // change taken once stages two and three agree
               if (s2[i] == s3[i]) begin
                  level[i] <= s3[i];
               end
            end
         end
      end
   endgenerate
endmodule : adt_sync

//--- adt_char_pack.sv
// character packing and unpacking for one datum
`timescale 1ns/10ps
module adt_char_pack
   import adt_pkg::*;
(
   input wire logic char_mode, // character transfers
   input wire logic phase, // second character of pair
   input wire logic [7:0] held_char, // first input character
   input wire word_t dev_word, // word from device
   input wire word_t mem_word, // word from memory
   output word_t to_mem, // word to store
   output word_t to_dev // datum to send
);
   always_comb begin
      if (char_mode) begin
         to_mem = {held_char, dev_word[7:0]};
      end else begin
         to_mem = dev_word;
      end
      if (!char_mode) begin
         to_dev = mem_word;
      end else if (phase) begin
         to_dev = {8'h00, mem_word[7:0]};
      end else begin
         to_dev = {8'h00, mem_word[15:8]};
      end
   end
endmodule : adt_char_pack

//--- auto_block_transfer.sv
// auto block transfer engine with wishbone register slave
`timescale 1ns/10ps
`include "adt_defines.svh"
module auto_block_transfer
   import adt_pkg::*;
(
   input wire logic sys_clk, // 25 MHz clock
   input wire logic reset, // async reset, active high
   input wire logic [7:0] adr_i, // wishbone byte address
   input wire logic [31:0] dat_i, // wishbone write data
   output logic [31:0] dat_o, // wishbone read data
   input wire logic [3:0] sel_i, // wishbone byte selects
   input wire logic we_i, // wishbone write
   input wire logic cyc_i, // wishbone cycle
   input wire logic stb_i, // wishbone strobe
   output logic ack_o, // wishbone acknowledge
   input wire logic insn_boundary, // instruction just finished
   input wire logic higher_irq_pending, // higher interrupt active
   input wire logic dev_data_req, // device datum request pin
   input wire logic [4:0] dev_station, // requesting station index
   output logic cpu_hold, // instruction flow held
   output logic mem_req, // memory request
   output logic mem_we, // memory write
   output maddr_t mem_addr, // memory word address
   output word_t mem_wdata, // memory write data
   input wire word_t mem_rdata, // memory read data
   input wire logic mem_ack, // memory acknowledge
   output logic io_req, // device datum request
   output logic io_we, // datum goes to device
   output logic [10:0] io_addr, // equipment and station
   output word_t io_wdata, // datum to device
   input wire word_t io_rdata, // datum from device
   input wire logic io_ack, // device acknowledge
   input wire logic io_err, // device transfer error
   output logic macro_irq // completion or error interrupt
);
   state_t state;
   logic micro_en;
   logic running;
   maddr_t table_addr;
   logic done_flag;
   logic err_flag;
   logic done_evt;
   logic err_evt;
   logic next_done;
   logic next_err;
   logic req_level;
   logic svc_go;
   logic multi;
   logic phase;
   logic [4:0] station;
   logic [7:0] held_char;
   word_t desc1;
   word_t cur;
   word_t last;
   word_t mem_word;
   maddr_t base;
   word_t pack_mem;
   word_t pack_dev;
   logic wb_hit;
   logic wr_ctrl;
   logic wr_table;
   logic wr_status;
   logic [5:0] reg_idx;
   logic char_mode;
   logic dir_out;
   word_t cur_inc;
   logic [1:0] data_count;

   adt_sync u_sync (
      .sys_clk(sys_clk),
      .reset(reset),
      .pin(dev_data_req),
      .level(req_level)
   );

   adt_char_pack u_pack (
      .char_mode(char_mode),
      .phase(phase),
      .held_char(held_char),
      .dev_word(io_rdata),
      .mem_word(mem_rdata),
      .to_mem(pack_mem),
      .to_dev(pack_dev)
   );

   assign char_mode = desc1[`D1_CHAR_BIT];
   assign dir_out = desc1[`D1_DIR_BIT];
   assign cur_inc = cur + 16'h0001;
   // boundary sampling, no new service in the cycle a block ends
   assign svc_go = running && micro_en && insn_boundary && req_level && !higher_irq_pending
                   && !done_evt && !err_evt;

   // register slave decode
   assign reg_idx = adr_i[7:2];
   assign wb_hit = cyc_i && stb_i && !ack_o;
   assign wr_ctrl = wb_hit && we_i && sel_i[0] && (reg_idx == `REG_CTRL);
   assign wr_table = wb_hit && we_i && (reg_idx == `REG_TABLE);
   assign wr_status = wb_hit && we_i && sel_i[0] && (reg_idx == `REG_STATUS);

   // flags: hardware set wins over software clear
   always_comb begin
      next_done = done_evt || (done_flag && !(wr_status && dat_i[`STAT_DONE_BIT]));
      next_err = err_evt || (err_flag && !(wr_status && dat_i[`STAT_ERR_BIT]));
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= wb_hit;
         dat_o <= 32'h0000_0000;
         if (wb_hit && !we_i) begin
            unique case (reg_idx)
               `REG_CTRL: dat_o <= {31'h0000_0000, micro_en};
               `REG_TABLE: dat_o <= {17'h0_0000, table_addr};
               `REG_STATUS: dat_o <= {27'h000_0000, cpu_hold, phase, running,
                                      err_flag, done_flag};
               `REG_POINTER: dat_o <= {16'h0000, cur};
               default: dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         micro_en <= 1'b0;
         table_addr <= `TABLE_RESET;
      end else begin
         if (wr_ctrl) begin
            micro_en <= dat_i[`CTRL_ENABLE_BIT];
         end
         if (wr_table && sel_i[0]) begin
            table_addr[7:0] <= dat_i[7:0];
         end
         if (wr_table && sel_i[1]) begin
            table_addr[14:8] <= dat_i[14:8];
         end
      end
   end

   // completion stops until software starts again
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         running <= 1'b0;
      end else if (done_evt || err_evt) begin
         running <= 1'b0;
      end else if (wr_ctrl && dat_i[`CTRL_START_BIT]) begin
         running <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         done_flag <= 1'b0;
         err_flag <= 1'b0;
         macro_irq <= 1'b0;
      end else begin
         done_flag <= next_done;
         err_flag <= next_err;
         macro_irq <= next_done || next_err;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state <= ST_IDLE;
         cpu_hold <= 1'b0;
         mem_req <= 1'b0;
         mem_we <= 1'b0;
         mem_addr <= 15'h0000;
         mem_wdata <= 16'h0000;
         io_req <= 1'b0;
         io_we <= 1'b0;
         io_addr <= 11'h000;
         io_wdata <= 16'h0000;
         desc1 <= 16'h0000;
         cur <= 16'h0000;
         last <= 16'h0000;
         mem_word <= 16'h0000;
         base <= 15'h0000;
         multi <= 1'b0;
         phase <= 1'b0;
         station <= 5'h00;
         held_char <= 8'h00;
         done_evt <= 1'b0;
         err_evt <= 1'b0;
      end else begin
         done_evt <= 1'b0;
         err_evt <= 1'b0;
         unique case (state)
            ST_IDLE: begin
               if (svc_go) begin
                  cpu_hold <= 1'b1;
                  station <= dev_station;
                  mem_req <= 1'b1;
                  mem_we <= 1'b0;
                  mem_addr <= table_addr;
                  state <= ST_HDR;
               end
            end
            ST_HDR: begin
               if (mem_ack) begin
                  // station block at four words per device
                  if (mem_rdata[`D1_MULTI_BIT] && mem_rdata[`D1_LINK_BIT]) begin
                     multi <= 1'b1;
                     base <= 15'(table_addr + 15'({station, 2'b00}) + `OFS_DEV_BASE);
                     mem_addr <= 15'(table_addr + 15'({station, 2'b00}) + `OFS_DEV_BASE);
                     state <= ST_DESC;
                  end else begin
                     multi <= 1'b0;
                     desc1 <= mem_rdata;
                     base <= table_addr;
                     mem_addr <= 15'(table_addr + `OFS_CUR);
                     state <= ST_CUR;
                  end
               end
            end
            ST_DESC: begin
               if (mem_ack) begin
                  desc1 <= mem_rdata;
                  mem_addr <= 15'(base + `OFS_CUR);
                  state <= ST_CUR;
               end
            end
            ST_CUR: begin
               if (mem_ack) begin
                  cur <= mem_rdata;
                  mem_addr <= 15'(base + `OFS_LAST);
                  state <= ST_LAST;
               end
            end
            ST_LAST: begin
               if (mem_ack) begin
                  last <= mem_rdata;
                  if (dir_out) begin
                     mem_addr <= cur_inc[14:0];
                     state <= ST_MEM_RD;
                  end else begin
                     mem_req <= 1'b0;
                     io_req <= 1'b1;
                     io_we <= 1'b0;
                     io_addr <= desc1[10:0];
                     state <= ST_IO;
                  end
               end
            end
            ST_MEM_RD: begin
               if (mem_ack) begin
                  mem_word <= mem_rdata;
                  mem_req <= 1'b0;
                  io_req <= 1'b1;
                  io_we <= 1'b1;
                  io_addr <= desc1[10:0];
                  io_wdata <= pack_dev;
                  state <= ST_IO;
               end
            end
            ST_IO: begin
               if (io_ack) begin
                  io_req <= 1'b0;
                  if (io_err) begin
                     err_evt <= 1'b1;
                     cpu_hold <= 1'b0;
                     state <= ST_IDLE;
                  end else if (char_mode && !phase) begin
                     held_char <= io_rdata[7:0];
                     phase <= 1'b1;
                     cpu_hold <= 1'b0;
                     state <= ST_IDLE;
                  end else if (!dir_out) begin
                     mem_req <= 1'b1;
                     mem_we <= 1'b1;
                     mem_addr <= cur_inc[14:0];
                     mem_wdata <= pack_mem;
                     state <= ST_MEM_WR;
                  end else begin
                     phase <= 1'b0;
                     cur <= cur_inc;
                     mem_req <= 1'b1;
                     mem_we <= 1'b1;
                     mem_addr <= 15'(base + `OFS_CUR);
                     mem_wdata <= cur_inc;
                     state <= ST_PTR_WR;
                  end
               end
            end
            ST_MEM_WR: begin
               if (mem_ack) begin
                  phase <= 1'b0;
                  cur <= cur_inc;
                  mem_addr <= 15'(base + `OFS_CUR);
                  mem_wdata <= cur_inc;
                  state <= ST_PTR_WR;
               end
            end
            ST_PTR_WR: begin
               if (mem_ack) begin
                  if (cur == last && multi) begin
                     mem_we <= 1'b0;
                     mem_addr <= station[4] ? 15'(table_addr + `OFS_TERM_HI)
                                            : 15'(table_addr + `OFS_TERM_LO);
                     state <= ST_TERM_RD;
                  end else begin
                     mem_req <= 1'b0;
                     mem_we <= 1'b0;
                     done_evt <= (cur == last);
                     cpu_hold <= 1'b0;
                     state <= ST_IDLE;
                  end
               end
            end
            ST_TERM_RD: begin
               if (mem_ack) begin
                  mem_we <= 1'b1;
                  mem_wdata <= mem_rdata | (16'h0001 << station[3:0]);
                  state <= ST_TERM_WR;
               end
            end
            ST_TERM_WR: begin
               if (mem_ack) begin
                  mem_req <= 1'b0;
                  mem_we <= 1'b0;
                  done_evt <= 1'b1;
                  cpu_hold <= 1'b0;
                  state <= ST_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         data_count <= 2'b00;
      end else if (!cpu_hold) begin
         data_count <= 2'b00;
      end else if (io_req && io_ack && data_count != 2'b11) begin
         data_count <= 2'(data_count + 2'b01);
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   sequence s_service_start;
      state == ST_IDLE && svc_go;
   endsequence
   sequence s_hold_then_fetch;
      cpu_hold && mem_req && !mem_we && mem_addr == $past(table_addr);
   endsequence

   boundary_start_a: assert property ($rose(cpu_hold) |-> $past(insn_boundary))
      else $error("hold began off an instruction boundary");
   start_fetch_a: assert property (s_service_start |=> s_hold_then_fetch)
      else $error("service did not fetch the table header");
   one_datum_a: assert property (data_count <= 2'b01)
      else $error("more than one datum in one service");
   priority_wait_a: assert property ((state == ST_IDLE && higher_irq_pending)
      |=> !$rose(cpu_hold))
      else $error("service began while a higher interrupt was active");
   macro_raise_a: assert property ((done_evt || err_evt) |=> macro_irq [*2])
      else $error("macro interrupt not raised after completion or error");
   dir_equipment_number_field_a: assert property (io_req
      |-> io_we == dir_out && io_addr[10:7] == desc1[10:7])
      else $error("device request direction or equipment wrong");
   char_in_pack_a: assert property ((state == ST_MEM_WR && char_mode)
      |-> mem_wdata[15:8] == held_char)
      else $error("first character not in upper byte");
   char_out_order_a: assert property ((io_req && io_we && char_mode)
      |-> io_wdata[7:0] == (phase ? mem_word[7:0] : mem_word[15:8]))
      else $error("character output order wrong");
   pointer_bump_a: assert property ((state == ST_MEM_WR && mem_ack)
      |=> cur == 16'($past(cur) + 16'h0001))
      else $error("pointer not advanced after store");
   block_done_a: assert property ((state == ST_PTR_WR && mem_ack && !multi && cur == last)
      |=> done_evt ##1 !running)
      else $error("block end not reported");
   term_flag_a: assert property ((state == ST_TERM_WR && mem_req)
      |-> mem_wdata[station[3:0]])
      else $error("termination flag not set");
endmodule : auto_block_transfer

//--- adt_far_side.sv
// memory and peripheral controller model facing the transfer engine
`timescale 1ns/10ps
module adt_far_side
   import adt_pkg::*;
(
   input wire logic sys_clk, // system clock
   input wire logic slow, // stretch every answer
   input wire logic armed, // device wants service
   input wire logic fail, // answer with an error
   input wire logic mem_req, // memory request
   input wire logic mem_we, // memory write
   input wire maddr_t mem_addr, // memory word address
   input wire word_t mem_wdata, // memory write data
   output word_t mem_rdata, // memory read data
   output logic mem_ack, // memory acknowledge
   input wire logic io_req, // datum request
   input wire logic io_we, // datum goes to device
   input wire word_t io_wdata, // datum to device
   output word_t io_rdata, // datum from device
   output logic io_ack, // device acknowledge
   output logic io_err, // transfer error
   output logic dev_data_req // datum wanted
);
   word_t mem [0:32767];
   word_t out_q [$];
   int n_io = 0;
   int mwait = 0;
   int iwait = 0;
   initial begin
      mem_ack = 1'b0;
      io_ack = 1'b0;
      io_err = 1'b0;
      mem_rdata = 16'h0000;
      io_rdata = 16'h0000;
   end
   // request only after software started it
   assign dev_data_req = armed;
   // idle read data toggles so stale values never match
   always @(posedge sys_clk) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack && mwait >= (slow ? 3 : 0)) begin
         mem_ack <= 1'b1;
         mem_rdata <= mem[mem_addr];
         if (mem_we) mem[mem_addr] <= mem_wdata;
         mwait <= 0;
      end else if (mem_req && !mem_ack) mwait <= mwait + 1;
   end
   // data transfer answers, one datum each
   always @(posedge sys_clk) begin
      io_ack <= 1'b0;
      io_err <= 1'b0;
      io_rdata <= ~io_rdata;
      if (io_req && !io_ack && iwait >= (slow ? 5 : 1)) begin
         io_ack <= 1'b1;
         io_err <= fail;
         io_rdata <= 16'hee40 + 16'(n_io);
         if (io_we) out_q.push_back(io_wdata);
         n_io <= n_io + 1;
         iwait <= 0;
      end else if (io_req && !io_ack) iwait <= iwait + 1;
   end
endmodule : adt_far_side

//--- auto_block_transfer_tb.sv
// self-checking bench for the auto block transfer engine
`timescale 1ns/10ps
module auto_block_transfer_tb;
   import adt_pkg::*;
   logic sys_clk, reset, we_i, cyc_i, stb_i, ack_o, insn_boundary, higher_irq_pending;
   logic dev_data_req, cpu_hold, mem_req, mem_we, mem_ack, io_req, io_we, io_ack, io_err;
   logic macro_irq, slow, armed, fail;
   logic [7:0] adr_i;
   logic [31:0] dat_i, dat_o, rd;
   logic [3:0] sel_i;
   logic [4:0] dev_station;
   logic [10:0] io_addr, seen_addr;
   maddr_t mem_addr;
   word_t mem_wdata, mem_rdata, io_wdata, io_rdata;
   int failures = 0;
   int n_tests = 0;
   int tick = 0;
   auto_block_transfer i_auto_block_transfer (.sys_clk, .reset, .adr_i, .dat_i, .dat_o, .sel_i,
      .we_i, .cyc_i, .stb_i, .ack_o, .insn_boundary, .higher_irq_pending, .dev_data_req,
      .dev_station, .cpu_hold, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack,
      .io_req, .io_we, .io_addr, .io_wdata, .io_rdata, .io_ack, .io_err, .macro_irq);
   adt_far_side i_adt_far_side (.sys_clk, .slow, .armed, .fail, .mem_req, .mem_we, .mem_addr,
      .mem_wdata, .mem_rdata, .mem_ack, .io_req, .io_we, .io_wdata, .io_rdata, .io_ack, .io_err,
      .dev_data_req);
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   // an instruction ends every third cycle
   always @(posedge sys_clk) begin
      tick <= tick + 1;
      insn_boundary <= (tick % 3 == 0);
      if (io_req) seen_addr <= io_addr;
   end
   function automatic logic [31:0] m(input maddr_t a);
      return 32'(i_adt_far_side.mem[a]);
   endfunction : m
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : end_of_test
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", what, exp, got);
         failures++;
      end
   endtask : check
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int k;
      @(posedge sys_clk);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      adr_i <= a;
      we_i <= w;
      dat_i <= d;
      sel_i <= 4'hf;
      k = 0;
      do begin
         @(posedge sys_clk);
         k++;
      end while (ack_o !== 1'b1 && k < 20);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
      if (k >= 20) begin
         failures++;
         end_of_test();
      end
   endtask : wb
   task automatic desc(input maddr_t t, input word_t w1, input word_t cur, input word_t last);
      i_adt_far_side.mem[t] = w1;
      i_adt_far_side.mem[t+1] = cur;
      i_adt_far_side.mem[t+2] = last;
      i_adt_far_side.mem[t+3] = 16'h0000;
   endtask : desc
   // start a block, wait for the interrupt, read status into rd and check it, then clear it
   task automatic go(input maddr_t t, input logic hold, input logic [31:0] stat);
      int k;
      wb(8'h04, 1'b1, 32'(t));
      wb(8'h00, 1'b1, 32'h0000_0003);
      armed <= 1'b1;
      higher_irq_pending <= hold;
      if (hold) begin
         repeat (40) begin
            @(posedge sys_clk);
            check("held off", 32'h0, 32'(cpu_hold));
         end
         higher_irq_pending <= 1'b0;
      end
      k = 0;
      while (macro_irq !== 1'b1 && k < 3000) begin
         @(posedge sys_clk);
         k++;
      end
      if (k >= 3000) begin
         failures++;
         end_of_test();
      end
      armed <= 1'b0;
      wb(8'h08, 1'b0, 32'h0);
      check("status", stat, rd);
      check("resumed", 32'h0, 32'(cpu_hold));
      wb(8'h08, 1'b1, 32'h0000_0003);
      @(posedge sys_clk);
      check("irq cleared", 32'h0, 32'(macro_irq));
   endtask : go
   task automatic t_regs();
      for (int i = 0; i < 5; i++) begin
         wb(8'(i * 4), 1'b0, 32'h0);
         check("reset value", 32'h0, rd);
      end
      wb(8'h10, 1'b1, 32'hffff_ffff);
      wb(8'h10, 1'b0, 32'h0);
      check("unmapped", 32'h0, rd);
      wb(8'h04, 1'b1, 32'hffff_ffff);
      wb(8'h04, 1'b0, 32'h0);
      check("table reg", 32'h0000_7fff, rd);
   endtask : t_regs
   task automatic t_word_in();
      int n0;
      n0 = i_adt_far_side.n_io;
      dev_station <= 5'd0;
      desc(15'h0100, 16'h0185, 16'h01ff, 16'h0201);
      go(15'h0100, 1'b1, 32'h0000_0001);
      check("word 0", 32'h0000_ee40 + 32'(n0), m(15'h0200));
      check("word 1", 32'h0000_ee41 + 32'(n0), m(15'h0201));
      check("pointer", 32'h0000_0201, m(15'h0101));
      check("device addr", 32'h0000_0185, 32'(seen_addr));
      check("datum count", 32'(n0 + 2), 32'(i_adt_far_side.n_io));
      check("no output", 32'h0, 32'(i_adt_far_side.out_q.size()));
   endtask : t_word_in
   task automatic t_char_out();
      i_adt_far_side.mem[15'h0300] = 16'ha55a;
      desc(15'h0110, 16'h2985, 16'h02ff, 16'h0300);
      go(15'h0110, 1'b0, 32'h0000_0001);
      check("char count", 32'h2, 32'(i_adt_far_side.out_q.size()));
      check("first char", 32'h0000_00a5, 32'(i_adt_far_side.out_q[0][7:0]));
      check("second char", 32'h0000_005a, 32'(i_adt_far_side.out_q[1][7:0]));
      check("pointer", 32'h0000_0300, m(15'h0111));
   endtask : t_char_out
   task automatic t_word_out();
      i_adt_far_side.mem[15'h0800] = 16'h1234;
      desc(15'h0140, 16'h0985, 16'h07ff, 16'h0800);
      go(15'h0140, 1'b0, 32'h0000_0001);
      check("word count", 32'h3, 32'(i_adt_far_side.out_q.size()));
      check("word out", 32'h0000_1234, 32'(i_adt_far_side.out_q[2]));
      check("pointer", 32'h0000_0800, m(15'h0141));
   endtask : t_word_out
   task automatic t_char_in();
      int n0;
      n0 = i_adt_far_side.n_io;
      slow <= 1'b1;
      desc(15'h0120, 16'h2185, 16'h03ff, 16'h0400);
      go(15'h0120, 1'b0, 32'h0000_0001);
      slow <= 1'b0;
      check("packed", 32'(16'h4041 + 16'h0101 * 16'(n0)), m(15'h0400));
      check("pointer", 32'h0000_0400, m(15'h0121));
      check("char count", 32'(n0 + 2), 32'(i_adt_far_side.n_io));
   endtask : t_char_in
   task automatic t_multi();
      dev_station <= 5'd1;
      desc(15'h0500, 16'h4186, 16'h0000, 16'h0000);
      desc(15'h0508, 16'h4185, 16'h05ff, 16'h0600);
      go(15'h0500, 1'b0, 32'h0000_0001);
      check("term low", 32'h0000_0002, m(15'h0501));
      check("term high", 32'h0, m(15'h0502));
      check("pointer", 32'h0000_0600, m(15'h0509));
   endtask : t_multi
   task automatic t_err();
      fail <= 1'b1;
      dev_station <= 5'd0;
      i_adt_far_side.mem[15'h0700] = 16'hbeef;
      desc(15'h0130, 16'h0185, 16'h06ff, 16'h0701);
      go(15'h0130, 1'b0, 32'h0000_0002);
      fail <= 1'b0;
      check("untouched", 32'h0000_beef, m(15'h0700));
      check("pointer kept", 32'h0000_06ff, m(15'h0131));
   endtask : t_err
   initial begin
      reset = 1'b1;
      {we_i, cyc_i, stb_i, insn_boundary, higher_irq_pending, slow, armed, fail} = 8'h00;
      adr_i = 8'h00;
      dat_i = 32'h0;
      sel_i = 4'h0;
      dev_station = 5'd0;
      repeat (10) @(posedge sys_clk);
      reset <= 1'b0;
      t_regs();
      t_word_in();
      t_char_out();
      t_word_out();
      t_char_in();
      t_multi();
      t_err();
      end_of_test();
   end
endmodule : auto_block_transfer_tb
